// [bcw_pkg.sv]
// Constants, field layout and state type of the buffer chain walker
package bcw_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_RX_HEAD     = 8'h04;
  localparam logic [7:0]  OFS_TX_HEAD     = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0c;
  localparam logic [7:0]  OFS_RX_PTR      = 8'h10;
  localparam logic [7:0]  OFS_TX_PTR      = 8'h14;
  // Control and status fields
  localparam int          CTRL_RX_EN_BIT  = 0;
  localparam int          CTRL_TX_EN_BIT  = 1;
  localparam int          ST_BUSY_BIT     = 0;
  localparam int          ST_RX_HELD_BIT  = 6;
  localparam int          ST_TX_HELD_BIT  = 7;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] PTR_RST         = 32'h0000_0000;
  localparam logic        HELD_RST        = 1'b0;
  // Buffer layout in word offsets from the buffer base
  localparam logic [31:0] LINK_WORD       = 32'h0000_0000;
  localparam logic [31:0] FSB_WORD        = 32'h0000_0001;
  localparam logic [31:0] DATA_WORD       = 32'h0000_0002;
  localparam int          FSB_DONE_BIT    = 31;
  localparam int          FSB_OVF_BIT     = 30;
  // Channels
  localparam int          CH_RX           = 0;
  localparam int          CH_TX           = 1;
  // Defaults
  localparam int          BUF_WORDS_DEF   = 64;
  localparam int          FIFO_DEPTH_DEF  = 32;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  typedef enum logic [2:0] {
    S_IDLE,
    S_LINK,
    S_WR_DATA,
    S_POST,
    S_TX_LEN,
    S_TX_RD
  } bcw_state_t;
endpackage

// [bcw_fifo_if.sv]
// Handshake bundle between the walker and its receive FIFO
`timescale 1ns/1ns
interface bcw_fifo_if #(parameter int W = 33);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;

  modport owner (output wdata, output wvalid, input wready,
                 input rdata, input rvalid, output rready);
  modport fifo  (input wdata, input wvalid, output wready,
                 output rdata, output rvalid, input rready);
endinterface

// [bcw_fifo.sv]
// Receive data FIFO with registered ready and registered read data
`timescale 1ns/1ns
module bcw_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = bcw_pkg::FIFO_DEPTH_DEF
) (
  // Clock, reset, enable
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // Both sides
  bcw_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          wready_r;
  logic          rvalid_r;
  logic [W-1:0]  rdata_r;
  logic          push;
  logic          load;

  assign push     = f.wvalid && wready_r;
  assign load     = (cnt_r != '0) && (!rvalid_r || f.rready);
  assign cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(load);
  assign f.wready = wready_r;
  assign f.rvalid = rvalid_r;
  assign f.rdata  = rdata_r;

  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
    begin
      mem[wp_r] <= f.wdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wp_r     <= '0;
      rp_r     <= '0;
      cnt_r    <= '0;
      wready_r <= 1'b1;
    end
    else if (ce_i)
    begin
      if (push)
        wp_r <= wp_r + AW'(1);
      if (load)
        rp_r <= rp_r + AW'(1);
      cnt_r    <= cnt_nxt;
      wready_r <= (cnt_nxt < (AW+1)'(DEPTH));
    end
  end

  // Output stage, the drainer sees only registered data
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
    end
    else if (ce_i)
    begin
      if (load)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= mem[rp_r];
      end
      else if (f.rready)
        rvalid_r <= 1'b0;
    end
  end
endmodule // bcw_fifo

// [bcw_top.sv]
// Receive and transmit buffer chain walker with AXI4-Lite registers
`timescale 1ns/1ns
module bcw_top #(
  parameter int BUF_WORDS  = bcw_pkg::BUF_WORDS_DEF,
  parameter int FIFO_DEPTH = bcw_pkg::FIFO_DEPTH_DEF
) (
  // Clock, reset, enable
  input  wire logic        CORE_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // Received frame words
  input  wire logic [31:0] RX_DATA_I,
  input  wire logic        RX_LAST_I,
  input  wire logic        RX_VALID_I,
  output logic             RX_READY_O,
  // Transmitted frame words
  output logic [31:0]      TX_DATA_O,
  output logic             TX_LAST_O,
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  // Buffer memory, word addressed
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic [31:0]      MEM_ADDR_O,
  output logic [31:0]      MEM_WDATA_O,
  input  wire logic        MEM_ACK_I,
  input  wire logic [31:0] MEM_RDATA_I
);
  localparam int          IDX_W  = $clog2(BUF_WORDS + 1);
  localparam logic [15:0] BUFW16 = 16'(BUF_WORDS);

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == bcw_pkg::OFS_CTRL)   || (a == bcw_pkg::OFS_RX_HEAD) ||
           (a == bcw_pkg::OFS_TX_HEAD) || (a == bcw_pkg::OFS_STATUS) ||
           (a == bcw_pkg::OFS_RX_PTR)  || (a == bcw_pkg::OFS_TX_PTR);
  endfunction

  // Bus slave state
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic [7:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic              wr_fire;
  logic [31:0]       ctrl_r;
  logic [7:0]        status;
  // Walker state
  bcw_pkg::bcw_state_t state_r;
  logic              chan_r;
  logic              rx_last_served_r;
  logic [31:0]       ptr_r [2];
  logic              held_r [2];
  logic [31:0]       buf_r;
  logic [IDX_W-1:0]  idx_r;
  logic [15:0]       len_r;
  logic              last_r;
  logic              ovf_r;
  logic              mem_req_r;
  logic              mem_we_r;
  logic [31:0]       mem_addr_r;
  logic [31:0]       mem_wdata_r;
  logic              mem_done;
  logic [31:0]       tx_data_r;
  logic              tx_last_r;
  logic              tx_valid_r;
  logic              rx_want;
  logic              tx_want;
  logic              pick_tx;
  logic [15:0]       tx_lim;

  bcw_fifo_if #(.W(33)) fi ();

  bcw_fifo #(
    .W     (33),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i  (CORE_CLK_I),
    .rstn_i (RSTN_I),
    .ce_i   (CE_I),
    .f      (fi.fifo)
  );

  assign fi.wdata  = {RX_LAST_I, RX_DATA_I};
  assign fi.wvalid = RX_VALID_I;
  assign fi.rready = (state_r == bcw_pkg::S_WR_DATA) && !mem_req_r && !last_r;
  assign RX_READY_O = fi.wready;

  assign mem_done = mem_req_r && MEM_ACK_I;
  assign rx_want  = ctrl_r[bcw_pkg::CTRL_RX_EN_BIT] && fi.rvalid;
  assign tx_want  = ctrl_r[bcw_pkg::CTRL_TX_EN_BIT];
  assign pick_tx  = tx_want && (!rx_want || rx_last_served_r);
  assign tx_lim   = (len_r > BUFW16) ? BUFW16 : len_r;
  assign wr_fire  = !awready_r && !wready_r && !bvalid_r;

  always_comb
  begin
    status = 8'h00;
    status[bcw_pkg::ST_BUSY_BIT]    = (state_r != bcw_pkg::S_IDLE);
    status[bcw_pkg::ST_RX_HELD_BIT] = held_r[bcw_pkg::CH_RX];
    status[bcw_pkg::ST_TX_HELD_BIT] = held_r[bcw_pkg::CH_TX];
  end

  // Write address and data taken in either order, answered after both
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= bcw_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else if (CE_I)
    begin
      if (S_AXI_AWVALID_I && awready_r)
      begin
        aw_addr_r <= S_AXI_AWADDR_I;
        awready_r <= 1'b0;
      end
      if (S_AXI_WVALID_I && wready_r)
      begin
        w_data_r <= S_AXI_WDATA_I;
        w_strb_r <= S_AXI_WSTRB_I;
        wready_r <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= is_mapped(aw_addr_r) ? bcw_pkg::RESP_OKAY : bcw_pkg::RESP_SLVERR;
      end
      if (bvalid_r && S_AXI_BREADY_I)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
      ctrl_r <= bcw_pkg::CTRL_RST;
    else if (CE_I && wr_fire && (aw_addr_r == bcw_pkg::OFS_CTRL))
      ctrl_r <= strb_merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0003;
  end

  // Read channel, data one cycle after the address is taken
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= bcw_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end
    else if (CE_I)
    begin
      if (S_AXI_ARVALID_I && arready_r)
      begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= is_mapped(S_AXI_ARADDR_I) ? bcw_pkg::RESP_OKAY : bcw_pkg::RESP_SLVERR;
        case (S_AXI_ARADDR_I)
          bcw_pkg::OFS_CTRL:    rdata_r <= ctrl_r;
          bcw_pkg::OFS_RX_HEAD: rdata_r <= ptr_r[bcw_pkg::CH_RX];
          bcw_pkg::OFS_TX_HEAD: rdata_r <= ptr_r[bcw_pkg::CH_TX];
          bcw_pkg::OFS_STATUS:  rdata_r <= {24'h00_0000, status};
          bcw_pkg::OFS_RX_PTR:  rdata_r <= ptr_r[bcw_pkg::CH_RX];
          bcw_pkg::OFS_TX_PTR:  rdata_r <= ptr_r[bcw_pkg::CH_TX];
          default:              rdata_r <= 32'h0000_0000;
        endcase
      end
      else if (rvalid_r && S_AXI_RREADY_I)
      begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Chain walker; host head writes win over the walker's own update
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_r          <= bcw_pkg::S_IDLE;
      chan_r           <= 1'b0;
      rx_last_served_r <= 1'b0;
      ptr_r[0]         <= bcw_pkg::PTR_RST;
      ptr_r[1]         <= bcw_pkg::PTR_RST;
      held_r[0]        <= bcw_pkg::HELD_RST;
      held_r[1]        <= bcw_pkg::HELD_RST;
      buf_r            <= 32'h0000_0000;
      idx_r            <= '0;
      len_r            <= 16'h0000;
      last_r           <= 1'b0;
      ovf_r            <= 1'b0;
      mem_req_r        <= 1'b0;
      mem_we_r         <= 1'b0;
      mem_addr_r       <= 32'h0000_0000;
      mem_wdata_r      <= 32'h0000_0000;
      tx_data_r        <= 32'h0000_0000;
      tx_last_r        <= 1'b0;
      tx_valid_r       <= 1'b0;
    end
    else if (CE_I)
    begin
      if (mem_done)
        mem_req_r <= 1'b0;
      if (tx_valid_r && TX_READY_I)
        tx_valid_r <= 1'b0;
      case (state_r)
        bcw_pkg::S_IDLE:
        begin
          if (rx_want || tx_want)
          begin
            chan_r           <= pick_tx;
            rx_last_served_r <= !pick_tx;
            buf_r            <= ptr_r[pick_tx];
            idx_r            <= '0;
            last_r           <= 1'b0;
            ovf_r            <= 1'b0;
            mem_req_r        <= 1'b1;
            mem_we_r         <= 1'b0;
            if (!held_r[pick_tx])
            begin
              mem_addr_r <= ptr_r[pick_tx];
              state_r    <= bcw_pkg::S_LINK;
            end
            else if (pick_tx)
            begin
              mem_addr_r <= ptr_r[pick_tx] + bcw_pkg::FSB_WORD;
              state_r    <= bcw_pkg::S_TX_LEN;
            end
            else
            begin
              mem_req_r <= 1'b0;
              state_r   <= bcw_pkg::S_WR_DATA;
            end
          end
        end
        bcw_pkg::S_LINK:
        begin
          if (mem_done)
          begin
            if (MEM_RDATA_I != 32'h0000_0000)
            begin
              ptr_r[chan_r]  <= MEM_RDATA_I;
              held_r[chan_r] <= 1'b1;
            end
            else
              held_r[chan_r] <= 1'b0;
            state_r <= bcw_pkg::S_IDLE;
          end
        end
        bcw_pkg::S_WR_DATA:
        begin
          if (!mem_req_r)
          begin
            if (last_r)
            begin
              mem_req_r   <= 1'b1;
              mem_we_r    <= 1'b1;
              mem_addr_r  <= buf_r + bcw_pkg::FSB_WORD;
              mem_wdata_r <= 32'h0000_0000;
              mem_wdata_r[bcw_pkg::FSB_DONE_BIT] <= 1'b1;
              mem_wdata_r[bcw_pkg::FSB_OVF_BIT]  <= ovf_r;
              mem_wdata_r[15:0] <= 16'(idx_r);
              state_r     <= bcw_pkg::S_POST;
            end
            else if (fi.rvalid)
            begin
              last_r <= fi.rdata[32];
              if (idx_r < IDX_W'(BUF_WORDS))
              begin
                mem_req_r   <= 1'b1;
                mem_we_r    <= 1'b1;
                mem_addr_r  <= buf_r + bcw_pkg::DATA_WORD + 32'(idx_r);
                mem_wdata_r <= fi.rdata[31:0];
                idx_r       <= idx_r + IDX_W'(1);
              end
              else
                ovf_r <= 1'b1;
            end
          end
        end
        bcw_pkg::S_POST:
        begin
          if (mem_done)
          begin
            // Frame posted; park on its link field, then try to advance
            ptr_r[chan_r]  <= buf_r + bcw_pkg::LINK_WORD;
            held_r[chan_r] <= 1'b0;
            mem_req_r      <= 1'b1;
            mem_we_r       <= 1'b0;
            mem_addr_r     <= buf_r + bcw_pkg::LINK_WORD;
            state_r        <= bcw_pkg::S_LINK;
          end
        end
        bcw_pkg::S_TX_LEN:
        begin
          if (mem_done)
          begin
            len_r   <= MEM_RDATA_I[15:0];
            state_r <= bcw_pkg::S_TX_RD;
          end
        end
        bcw_pkg::S_TX_RD:
        begin
          if (mem_done)
          begin
            tx_data_r  <= MEM_RDATA_I;
            tx_valid_r <= 1'b1;
            tx_last_r  <= (16'(idx_r) + 16'h0001 == tx_lim);
            idx_r      <= idx_r + IDX_W'(1);
          end
          else if (!mem_req_r && !tx_valid_r)
          begin
            mem_req_r <= 1'b1;
            if (16'(idx_r) >= tx_lim)
            begin
              mem_we_r    <= 1'b1;
              mem_addr_r  <= buf_r + bcw_pkg::FSB_WORD;
              mem_wdata_r <= 32'h0000_0000;
              mem_wdata_r[bcw_pkg::FSB_DONE_BIT] <= 1'b1;
              mem_wdata_r[bcw_pkg::FSB_OVF_BIT]  <= (len_r > BUFW16);
              mem_wdata_r[15:0] <= len_r;
              state_r     <= bcw_pkg::S_POST;
            end
            else
            begin
              mem_we_r   <= 1'b0;
              mem_addr_r <= buf_r + bcw_pkg::DATA_WORD + 32'(idx_r);
            end
          end
        end
        default:
          state_r <= bcw_pkg::S_IDLE;
      endcase
      if (wr_fire && (aw_addr_r == bcw_pkg::OFS_RX_HEAD))
      begin
        ptr_r[bcw_pkg::CH_RX]  <= strb_merge(ptr_r[bcw_pkg::CH_RX], w_data_r, w_strb_r);
        held_r[bcw_pkg::CH_RX] <= 1'b1;
      end
      if (wr_fire && (aw_addr_r == bcw_pkg::OFS_TX_HEAD))
      begin
        ptr_r[bcw_pkg::CH_TX]  <= strb_merge(ptr_r[bcw_pkg::CH_TX], w_data_r, w_strb_r);
        held_r[bcw_pkg::CH_TX] <= 1'b1;
      end
    end
  end

  assign S_AXI_AWREADY_O = awready_r;
  assign S_AXI_WREADY_O  = wready_r;
  assign S_AXI_BVALID_O  = bvalid_r;
  assign S_AXI_BRESP_O   = bresp_r;
  assign S_AXI_ARREADY_O = arready_r;
  assign S_AXI_RVALID_O  = rvalid_r;
  assign S_AXI_RRESP_O   = rresp_r;
  assign S_AXI_RDATA_O   = rdata_r;
  assign TX_DATA_O       = tx_data_r;
  assign TX_LAST_O       = tx_last_r;
  assign TX_VALID_O      = tx_valid_r;
  assign MEM_REQ_O       = mem_req_r;
  assign MEM_WE_O        = mem_we_r;
  assign MEM_ADDR_O      = mem_addr_r;
  assign MEM_WDATA_O     = mem_wdata_r;
endmodule // bcw_top

// [bcw_props.sv]
// Timing checks of the walker's bus, stream and memory port
`timescale 1ns/1ns
module bcw_props (
  // Clock and reset
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  // Register bus
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic [7:0]  S_AXI_ARADDR_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0]  S_AXI_RRESP_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  // Stream and memory
  input wire logic [31:0] TX_DATA_O,
  input wire logic        TX_VALID_O,
  input wire logic        TX_READY_I,
  input wire logic        MEM_REQ_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic        MEM_ACK_I
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O) else $error("write answer");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
    && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O
    && !S_AXI_ARREADY_O) else $error("read answer");
  r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O
    && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  bad_read_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    && S_AXI_ARADDR_I > bcw_pkg::OFS_TX_PTR |=> S_AXI_RRESP_O == bcw_pkg::RESP_SLVERR
    && S_AXI_RDATA_O == 32'h0) else $error("unmapped read answer");
  mem_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O
    && $stable(MEM_ADDR_O)) else $error("memory request dropped");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O
    && $stable(TX_DATA_O)) else $error("transmit word dropped");
  rst_state_a: assert property ($rose(RSTN_I) |-> S_AXI_AWREADY_O && S_AXI_ARREADY_O
    && !S_AXI_BVALID_O && !S_AXI_RVALID_O && !MEM_REQ_O && !TX_VALID_O)
    else $error("reset state");
  wr_c: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  tx_c: cover property (TX_VALID_O && TX_READY_I);
  mem_c: cover property (MEM_REQ_O && MEM_ACK_I);
endmodule // bcw_props

bind bcw_top bcw_props u_bcw_props (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O),
  .TX_READY_I(TX_READY_I), .MEM_REQ_O(MEM_REQ_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_ACK_I(MEM_ACK_I)
);

// [bcw_host_mem.sv]
// Host buffer memory answering the walker's word accesses
`timescale 1ns/1ns
module bcw_host_mem (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Access port
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        slow_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_r;
  logic [31:0] noise_r = 32'h5a5a_0f0f;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  // Outside the acknowledge cycle the data lines carry junk
  assign rdata_o = ack_o ? mem[addr_i[7:0]] : ~noise_r;
  always @(posedge clk_i) noise_r <= noise_r + 32'h0000_3b5d;
  always @(posedge clk_i)
  begin
    if (!rstn_i || ack_o)
    begin
      ack_o <= 1'b0;
      wait_r <= 2'd0;
    end
    else if (req_i)
    begin
      if (slow_i && wait_r != 2'd3)
        wait_r <= wait_r + 2'd1;
      else
      begin
        ack_o <= 1'b1;
        if (we_i) mem[addr_i[7:0]] <= wdata_i;
      end
    end
  end
endmodule // bcw_host_mem

// [tb_bcw_top.sv]
// Self-checking bench of the buffer chain walker
`timescale 1ns/1ns
module tb_bcw_top;
  localparam int BW = 4;
  localparam logic [31:0] A = 32'h10, B = 32'h20, C = 32'h30, T = 32'h40;
  localparam logic [31:0] RXH = 32'h1 << bcw_pkg::ST_RX_HELD_BIT;
  localparam logic [31:0] TXH = 32'h1 << bcw_pkg::ST_TX_HELD_BIT;
  localparam logic [1:0]  OK = bcw_pkg::RESP_OKAY;
  logic        clk = 0, rstn = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rxd = 0, lf_a = 32'd87, lf_b = 32'd87;
  logic        rxl = 0, rxv = 0, txr = 0, slow = 0;
  logic [3:0]  ws = 4'hf;
  logic        awr, wr, bv, arr, rv, rxr, txv, txl, req, we, ack;
  logic [1:0]  br, rr;
  logic [31:0] rd, txd, ma, mwd, mrd;
  int          failures = 0, samples_checked = 0, k;
  logic [1:0]  exp_b [$];
  logic [33:0] exp_r [$];
  logic [63:0] exp_w [$];
  logic [32:0] exp_t [$];

  always #4 clk = ~clk;

  bcw_top #(.BUF_WORDS(BW), .FIFO_DEPTH(bcw_pkg::FIFO_DEPTH_DEF)) u_bcw_top (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brd),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrd), .RX_DATA_I(rxd),
    .RX_LAST_I(rxl), .RX_VALID_I(rxv), .RX_READY_O(rxr), .TX_DATA_O(txd), .TX_LAST_O(txl),
    .TX_VALID_O(txv), .TX_READY_I(txr), .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_ADDR_O(ma),
    .MEM_WDATA_O(mwd), .MEM_ACK_I(ack), .MEM_RDATA_I(mrd));
  bcw_host_mem u_bcw_host_mem (.clk_i(clk), .rstn_i(rstn), .req_i(req), .we_i(we),
    .addr_i(ma), .wdata_i(mwd), .slow_i(slow), .ack_o(ack), .rdata_o(mrd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random stalls of the transmit sink and of the memory
  always @(posedge clk)
  begin
    lf_b <= lfsr(lf_b);
    txr <= lf_b[0] | lf_b[1];
    slow <= lf_b[2];
  end

  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Monitor: each observed result against the oldest note
  always @(posedge clk)
  begin
    if (bv && brd) chk("bresp", exp_b.pop_front(), br);
    if (rv && rrd) chk("read", exp_r.pop_front(), {rr, rd});
    if (txv && txr) chk("tx word", exp_t.pop_front(), {txl, txd});
    if (req && ack && we) chk("mem write", exp_w.pop_front(), {ma, mwd});
  end

  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1 || wr !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    brd <= 1'b0;
  endtask

  task axi_rd(input logic [7:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rrd <= 1'b0;
  endtask

  task rx_frame(input logic [31:0] base, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      lf_a = lfsr(lf_a);
      if (i < BW) exp_w.push_back({base + 32'(2 + i), lf_a});
      rxd <= lf_a;
      rxl <= (i == n - 1);
      rxv <= 1'b1;
      do @(posedge clk); while (rxr !== 1'b1);
    end
    rxv <= 1'b0;
    rxl <= 1'b0;
    exp_w.push_back({base + 32'h1, 32'h8000_0000 | (n > BW ? 32'h4000_0000 : 32'h0)
      | 32'(n > BW ? BW : n)});
  endtask

  task settle;
    int n;
    n = 0;
    while (exp_w.size() + exp_t.size() != 0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
  endtask

  task complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    axi_rd(bcw_pkg::OFS_STATUS, {OK, 32'h0});
    axi_rd(bcw_pkg::OFS_RX_PTR, {OK, bcw_pkg::PTR_RST});
    axi_rd(8'h40, {bcw_pkg::RESP_SLVERR, 32'h0});
    axi_wr(8'h40, 32'h1, bcw_pkg::RESP_SLVERR);
    axi_wr(bcw_pkg::OFS_RX_HEAD, A, OK);
    axi_wr(bcw_pkg::OFS_STATUS, 32'hffff_ffff, OK);
    axi_rd(bcw_pkg::OFS_STATUS, {OK, RXH});
    axi_wr(bcw_pkg::OFS_CTRL, 32'h1, OK);
    rx_frame(A, 2);
    settle;
    axi_rd(bcw_pkg::OFS_RX_PTR, {OK, A});
    axi_rd(bcw_pkg::OFS_STATUS, {OK, 32'h0});
    u_bcw_host_mem.mem[B] = C;
    u_bcw_host_mem.mem[A] = B;
    rx_frame(B, BW);
    settle;
    axi_rd(bcw_pkg::OFS_RX_PTR, {OK, C});
    axi_rd(bcw_pkg::OFS_STATUS, {OK, RXH});
    chk("posted block", 32'h8000_0004, u_bcw_host_mem.mem[B + 32'h1]);
    axi_wr(bcw_pkg::OFS_CTRL, 32'h0, OK);
    k = 0;
    fork
      rx_frame(C, 34);
      begin
        repeat (40)
        begin
          @(posedge clk);
          if (rxv === 1'b1 && rxr === 1'b1) k++;
        end
        chk("fifo fill", bcw_pkg::FIFO_DEPTH_DEF + 1, k);
        chk("fifo refusal", 0, rxr);
        axi_wr(bcw_pkg::OFS_CTRL, 32'h1, OK);
      end
    join
    settle;
    axi_rd(bcw_pkg::OFS_RX_PTR, {OK, C});
    axi_rd(bcw_pkg::OFS_STATUS, {OK, 32'h0});
    u_bcw_host_mem.mem[T + 32'h1] = 32'h2;
    for (int i = 0; i < 2; i++)
    begin
      lf_a = lfsr(lf_a);
      u_bcw_host_mem.mem[T + 32'(2 + i)] = lf_a;
      exp_t.push_back({i == 1, lf_a});
    end
    axi_wr(bcw_pkg::OFS_CTRL, 32'h0, OK);
    // Byte-lane write: only the low byte may land
    ws <= 4'h1;
    axi_wr(bcw_pkg::OFS_TX_HEAD, 32'hffff_ff00 | T, OK);
    ws <= 4'hf;
    axi_rd(bcw_pkg::OFS_TX_PTR, {OK, T});
    axi_rd(bcw_pkg::OFS_STATUS, {OK, TXH});
    exp_w.push_back({T + 32'h1, 32'h8000_0002});
    axi_wr(bcw_pkg::OFS_CTRL, 32'h2, OK);
    settle;
    axi_wr(bcw_pkg::OFS_CTRL, 32'h0, OK);
    settle;
    axi_rd(bcw_pkg::OFS_TX_PTR, {OK, T});
    axi_rd(bcw_pkg::OFS_STATUS, {OK, 32'h0});
    chk("queues drained", 0, exp_w.size() + exp_t.size());
    complete_run;
  end
endmodule // tb_bcw_top
